// ---- src/asd_config_regs.sv ----
// APB register bank for input trim, core swap delays and dither control
`timescale 1ns/1ns
module asd_config_regs
  import asd_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic sys_clk, // 125 MHz system clock
  input wire logic rst_b, // synchronous reset, active low
  input wire logic ce, // clock enable, freezes all state
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [ADDR_W-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [3:0] pstrb, // apb byte strobes
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic [asd_pkg::TRIM_W-1:0] factory_trim, // fuse value
  input wire logic cal_enable, // background calibration enable pin
  input wire logic swap_request, // core swap request pin
  output logic [asd_pkg::TRIM_W-1:0] input_d_termination_trim, // trim
  output logic dither_enable, // dither on
  output logic dither_amplitude_select, // large dither
  output logic dither_rounding_select, // error into offset and spurs
  output logic overlap_active, // both cores sample the same input
  output logic steer_select, // encoder mux select
  output logic swap_busy // swap sequence in progress
);
  import asd_pkg::*;

  // elaboration check: the highest index must fit the address
  if (ADDR_W < 10 + ADDR_LSB) begin : g_addr_chk
    $error("asd_config_regs: ADDR_W too small for register map");
  end

  // decode a byte address into a register hit
  function automatic logic hit(input logic [ADDR_W-1:0] addr,
                               input logic [9:0] idx);
    hit = (addr[ADDR_LSB +: 10] == idx) &&
          ((addr >> (ADDR_LSB + 10)) == '0) &&
          (addr[ADDR_LSB-1:0] == '0);
  endfunction : hit

  logic [TRIM_W-1:0] trim_ff;
  logic [DLY_W-1:0] overlap_ff;
  logic [DLY_W-1:0] steer_ff;
  logic [DITH_W-1:0] dither_ff;
  logic [31:0] prdata_ff;
  logic pslverr_ff;
  logic [1:0] load_wait_ff;
  logic trim_loaded_ff;
  logic [TRIM_W-1:0] fuse_sync;
  logic cal_sync;
  logic req_sync;
  logic req_dly_ff;
  logic req_rise;
  logic wr_en;
  logic setup;
  logic mapped;
  logic [31:0] nxt_rdata;
  asd_swap_type state_ff;
  asd_swap_type nxt_state;
  logic [DLY_W-1:0] overlap_snap_ff;
  logic [DLY_W-1:0] steer_snap_ff;
  logic steer_sel_ff;
  logic ovl_start;
  logic ovl_busy;
  logic ovl_done;
  logic str_start;
  logic str_done;
  logic [CNT_W-1:0] ovl_len;
  logic [CNT_W-1:0] str_len;

  // synchronise the pins before anything reads them
  asd_sync #(.W(TRIM_W)) u_fuse_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .ce(ce),
    .async_in(factory_trim),
    .sync_out(fuse_sync)
  );

  asd_sync #(.W(2)) u_ctl_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .ce(ce),
    .async_in({cal_enable, swap_request}),
    .sync_out({cal_sync, req_sync})
  );

  // apb phases; the slave never waits, so pready is constant high
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite && pstrb[0];
  assign mapped = hit(paddr, TRIM_IDX) || hit(paddr, OVERLAP_IDX) ||
                  hit(paddr, STEER_IDX) || hit(paddr, DITHER_IDX);

  // read mux; reserved bits read as zero
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (hit(paddr, TRIM_IDX)) begin
      nxt_rdata[TRIM_W-1:0] = trim_ff;
    end else if (hit(paddr, OVERLAP_IDX)) begin
      nxt_rdata[DLY_W-1:0] = overlap_ff;
    end else if (hit(paddr, STEER_IDX)) begin
      nxt_rdata[DLY_W-1:0] = steer_ff;
    end else if (hit(paddr, DITHER_IDX)) begin
      nxt_rdata[DITH_W-1:0] = dither_ff;
    end
  end

  // side-effect free read
  // read data is captured in the setup cycle and held for the access cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (ce) begin
      if (setup) begin
        prdata_ff <= pwrite ? 32'h0000_0000 : nxt_rdata;
        pslverr_ff <= !mapped;
      end
    end
  end

  assign prdata = prdata_ff;
  assign pready = 1'b1;
  assign pslverr = pslverr_ff && psel && penable;

  // factory trim load
  // wait until the fuse value has crossed both synchroniser stages
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      load_wait_ff <= 2'h0;
      trim_loaded_ff <= 1'b0;
    end else if (ce) begin
      if (load_wait_ff != FACTORY_LOAD_WAIT) begin
        load_wait_ff <= load_wait_ff + 2'h1;
      end
      if (load_wait_ff == FACTORY_LOAD_WAIT) begin
        trim_loaded_ff <= 1'b1;
      end
    end
  end

  // trim register
  // the fuse value lands once; software writes win afterwards
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      trim_ff <= TRIM_RST;
    end else if (ce) begin
      if (wr_en && hit(paddr, TRIM_IDX)) begin
        trim_ff <= pwdata[TRIM_W-1:0];
      end else if (!trim_loaded_ff &&
                   load_wait_ff == FACTORY_LOAD_WAIT) begin
        trim_ff <= fuse_sync;
      end
    end
  end

  // is left to software; the running swap uses a snapshot anyway
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      overlap_ff <= OVERLAP_RST;
    end else if (ce) begin
      if (wr_en && hit(paddr, OVERLAP_IDX)) begin
        overlap_ff <= pwdata[DLY_W-1:0];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      steer_ff <= STEER_RST;
    end else if (ce) begin
      if (wr_en && hit(paddr, STEER_IDX)) begin
        steer_ff <= pwdata[DLY_W-1:0];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      dither_ff <= DITHER_RST;
    end else if (ce) begin
      if (wr_en && hit(paddr, DITHER_IDX)) begin
        dither_ff <= pwdata[DITH_W-1:0];
      end
    end
  end

  assign dither_enable = dither_ff[DITH_EN_BIT];
  assign dither_amplitude_select = dither_ff[DITH_AMP_BIT];
  assign dither_rounding_select = dither_ff[DITH_ERR_BIT];
  assign input_d_termination_trim = trim_ff;

  // swap request edge, taken from the synchronised copy
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      req_dly_ff <= 1'b0;
    end else if (ce) begin
      req_dly_ff <= req_sync;
    end
  end

  assign req_rise = req_sync && !req_dly_ff;

  // swap sequencer: overlap window, then delayed mux select change
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      SW_IDLE: begin
        if (req_rise && cal_sync) begin
          nxt_state = SW_OVERLAP;
        end
      end
      SW_OVERLAP: begin
        if (ovl_done) begin
          nxt_state = SW_STEER;
        end
      end
      SW_STEER: begin
        if (str_done) begin
          nxt_state = SW_IDLE;
        end
      end
      default: begin
        nxt_state = SW_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state_ff <= SW_IDLE;
    end else if (ce) begin
      state_ff <= nxt_state;
    end
  end

  // freeze delays at swap start so a late write cannot bend a swap
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      overlap_snap_ff <= OVERLAP_RST;
      steer_snap_ff <= STEER_RST;
    end else if (ce) begin
      if (state_ff == SW_IDLE) begin
        overlap_snap_ff <= overlap_ff;
        steer_snap_ff <= steer_ff;
      end
    end
  end

  // overlap length of base plus twice the value
  assign ovl_len = CNT_W'(OVERLAP_BASE) +
                   CNT_W'(OVERLAP_SCALE) * CNT_W'(overlap_snap_ff);
  assign ovl_start = (state_ff == SW_IDLE) && req_rise && cal_sync;

  asd_cycle_timer #(.W(CNT_W)) u_overlap_tmr (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .ce(ce),
    .start(ovl_start),
    .load_val(ovl_len),
    .busy(ovl_busy),
    .done(ovl_done)
  );

  // select delay applied only within a swap
  assign str_len = CNT_W'(steer_snap_ff);
  assign str_start = ovl_done;

  asd_cycle_timer #(.W(CNT_W)) u_steer_tmr (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .ce(ce),
    .start(str_start),
    .load_val(str_len),
    .busy(),
    .done(str_done)
  );

  // mux select flips when the delay runs out
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      steer_sel_ff <= 1'b0;
    end else if (ce) begin
      if (str_done) begin
        steer_sel_ff <= !steer_sel_ff;
      end
    end
  end

  assign overlap_active = ovl_busy;
  assign steer_select = steer_sel_ff;
  assign swap_busy = (state_ff != SW_IDLE);
endmodule : asd_config_regs

// ---- shared/asd_pkg.sv ----
// constants for the swap, dither and trim configuration registers
package asd_pkg;
  // register indices; byte address is four times the index
  localparam logic [9:0] TRIM_IDX = 10'h081;
  localparam logic [9:0] OVERLAP_IDX = 10'h09A;
  localparam logic [9:0] STEER_IDX = 10'h09B;
  localparam logic [9:0] DITHER_IDX = 10'h09D;
  localparam int ADDR_LSB = 2;
  // field layouts
  localparam int TRIM_W = 8;
  localparam int DLY_W = 5;
  localparam int DITH_EN_BIT = 0;
  localparam int DITH_AMP_BIT = 1;
  localparam int DITH_ERR_BIT = 2;
  localparam int DITH_W = 3;
  // reset values
  localparam logic [7:0] TRIM_RST = 8'h00;
  localparam logic [4:0] OVERLAP_RST = 5'h08;
  localparam logic [4:0] STEER_RST = 5'h07;
  localparam logic [2:0] DITHER_RST = 3'h0;
  // overlap length is base plus twice the programmed value
  localparam int OVERLAP_BASE = 4;
  localparam int OVERLAP_SCALE = 2;
  localparam int CNT_W = 7;
  // edges after reset release before the factory trim is taken
  localparam logic [1:0] FACTORY_LOAD_WAIT = 2'h3;
  typedef enum logic [1:0] {SW_IDLE, SW_OVERLAP, SW_STEER} asd_swap_type;
endpackage : asd_pkg

// ---- src/asd_sync.sv ----
// two flip-flop synchroniser for signals arriving from outside the clock
`timescale 1ns/1ns
module asd_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk, // system clock
  input wire logic rst_b, // synchronous reset, active low
  input wire logic ce, // clock enable
  input wire logic [W-1:0] async_in, // unsynchronised input
  output logic [W-1:0] sync_out // synchronised copy
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // first stage feeds only the second stage
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else if (ce) begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule : asd_sync

// ---- src/asd_cycle_timer.sv ----
// down counter that stays busy for a loaded number of cycles
`timescale 1ns/1ns
module asd_cycle_timer #(
  parameter int W = 7
) (
  input wire logic sys_clk, // system clock
  input wire logic rst_b, // synchronous reset, active low
  input wire logic ce, // clock enable
  input wire logic start, // load the count
  input wire logic [W-1:0] load_val, // number of busy cycles
  output logic busy, // count still running
  output logic done // one-cycle pulse at the end
);
  logic [W-1:0] cnt_ff;
  logic done_ff;

  // count down; a zero load finishes on the next edge
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      cnt_ff <= '0;
      done_ff <= 1'b0;
    end else if (ce) begin
      done_ff <= 1'b0;
      if (start) begin
        cnt_ff <= load_val;
        done_ff <= (load_val == '0);
      end else if (cnt_ff != '0) begin
        cnt_ff <= cnt_ff - 1'b1;
        done_ff <= (cnt_ff == {{(W-1){1'b0}}, 1'b1});
      end
    end
  end

  assign busy = (cnt_ff != '0);
  assign done = done_ff;
endmodule : asd_cycle_timer

// ---- bench/asd_config_regs_monitor.sv ----
// port checker for the configuration register bank
`timescale 1ns/1ns
module asd_config_regs_monitor
  import asd_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic sys_clk, // clock
  input wire logic rst_b, // reset, active low
  input wire logic ce, // clock enable
  input wire logic psel, // apb select
  input wire logic penable, // apb access
  input wire logic pwrite, // apb write
  input wire logic [ADDR_W-1:0] paddr, // byte address
  input wire logic [31:0] pwdata, // write data
  input wire logic [3:0] pstrb, // byte strobes
  input wire logic pslverr, // apb error
  input wire logic [7:0] input_d_termination_trim, // trim
  input wire logic dither_enable, // dither on
  input wire logic dither_amplitude_select, // large dither
  input wire logic dither_rounding_select, // rounding target
  input wire logic overlap_active, // shared sampling
  input wire logic steer_select, // encoder select
  input wire logic swap_busy // swap running
);
  localparam logic [ADDR_W-1:0] A_TRIM = ADDR_W'({TRIM_IDX, 2'b00});
  localparam logic [ADDR_W-1:0] A_DITH = ADDR_W'({DITHER_IDX, 2'b00});
  // a completed lane-0 write; ce low would freeze it
  wire wr_go = psel && penable && pwrite && pstrb[0] && ce;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  trim_write_a: assert property (wr_go && paddr == A_TRIM
    |=> input_d_termination_trim == $past(pwdata[7:0])) else $error("trim");
  dith_enable_a: assert property (wr_go && paddr == A_DITH
    |=> dither_enable == $past(pwdata[0])) else $error("dither enable");
  dith_amp_a: assert property (wr_go && paddr == A_DITH
    |=> dither_amplitude_select == $past(pwdata[1])) else $error("amp");
  dith_round_a: assert property (wr_go && paddr == A_DITH
    |=> dither_rounding_select == $past(pwdata[2])) else $error("round");
  overlap_min_a: assert property ($rose(overlap_active)
    |-> overlap_active[*4]) else $error("overlap too short");
  overlap_max_a: assert property ($rose(overlap_active)
    |-> ##[4:66] !overlap_active) else $error("overlap too long");
  steer_busy_a: assert property ($changed(steer_select)
    |-> $past(swap_busy) && !overlap_active) else $error("steer moved");
  steer_flip_a: assert property ($fell(swap_busy)
    |-> $changed(steer_select)) else $error("steer stuck");
  read_quiet_a: assert property (psel && !pwrite
    |=> $stable(input_d_termination_trim)) else $error("read changed trim");
endmodule : asd_config_regs_monitor

// ---- bench/test_asd_config_regs.sv ----
// self-checking bench for the configuration register bank
`timescale 1ns/1ns
module test_asd_config_regs;
  import asd_pkg::*;
  logic sys_clk = 0, rst_b = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [3:0] pstrb = 4'hF;
  logic [7:0] factory_trim = 8'h5A, input_d_termination_trim;
  logic cal_enable = 0, swap_request = 0, pready, pslverr, err, s;
  logic dither_enable, dither_amplitude_select, dither_rounding_select;
  logic overlap_active, steer_select, swap_busy;
  int bad_count = 0, check_count = 0, cyc = 0, n;
  // seven stands for the slow-clock overlap choice
  int v[4] = '{0, 7, 8, 31};
  // clock at 125 MHz
  always #4 sys_clk = ~sys_clk;
  asd_config_regs uut (.sys_clk, .rst_b, .ce, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .factory_trim,
    .cal_enable, .swap_request, .input_d_termination_trim, .dither_enable,
    .dither_amplitude_select, .dither_rounding_select, .overlap_active,
    .steer_select, .swap_busy);
  task chk(input string nm, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one apb transfer; held until pready is seen at an edge
  task apb(input logic w, input logic [9:0] i, input logic [1:0] lo,
    input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= {i, lo};
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task rdchk(input string nm, input logic [9:0] i, input logic [31:0] e);
    apb(0, i, 0, 0);
    chk(nm, e, rd);
  endtask : rdchk
  task t_reset(input logic [7:0] ft);
    // every reset reloads the fuse value
    rst_b <= 0;
    factory_trim <= ft;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1;
    // factory trim lands on the fourth edge after release
    repeat (6) @(posedge sys_clk);
    rdchk("trim", TRIM_IDX, {24'h0, ft});
    rdchk("overlap", OVERLAP_IDX, 32'h08);
    rdchk("steer", STEER_IDX, 32'h07);
    rdchk("dither", DITHER_IDX, 32'h0);
    $display("reset values done");
  endtask : t_reset
  task t_fields;
    // reserved bits are always written as zero
    apb(1, TRIM_IDX, 0, 32'hA5);
    // pins settle after the write edge, so look mid-cycle
    @(negedge sys_clk);
    chk("trim pin", 8'hA5, input_d_termination_trim);
    rdchk("trim", TRIM_IDX, 32'hA5);
    apb(1, OVERLAP_IDX, 0, 32'h1F);
    rdchk("overlap", OVERLAP_IDX, 32'h1F);
    apb(1, STEER_IDX, 0, 32'h1F);
    rdchk("steer", STEER_IDX, 32'h1F);
    for (int i = 7; i >= 0; i--) begin
      apb(1, DITHER_IDX, 0, i);
      @(negedge sys_clk);
      chk("dither pins", i, {dither_rounding_select,
        dither_amplitude_select, dither_enable});
      rdchk("dither", DITHER_IDX, i);
    end
    $display("field tests done");
  endtask : t_fields
  task t_unmapped;
    apb(1, 10'h09C, 0, 32'h1);
    chk("slverr", 1, err);
    apb(0, DITHER_IDX, 2'h1, 0);
    chk("misaligned err", 1, err);
    chk("misaligned data", 0, rd);
    // lane 0 strobe off: the write must not land
    pstrb <= 4'hE;
    apb(1, TRIM_IDX, 0, 32'h3C);
    pstrb <= 4'hF;
    rdchk("trim kept", TRIM_IDX, 32'hA5);
    // clock enable low freezes the bank, so this write is lost
    ce <= 0;
    apb(1, TRIM_IDX, 0, 32'h3C);
    ce <= 1;
    rdchk("frozen trim", TRIM_IDX, 32'hA5);
    $display("error tests done");
  endtask : t_unmapped
  task t_swap;
    cal_enable <= 0;
    swap_request <= 1;
    repeat (10) @(posedge sys_clk);
    chk("refused", 0, swap_busy);
    swap_request <= 0;
    for (int k = 0; k < 4; k++) begin
      // delays change only with calibration off
      cal_enable <= 0;
      apb(1, OVERLAP_IDX, 0, v[k]);
      // steer delay is swept by software, not derived
      apb(1, STEER_IDX, 0, v[3-k]);
      cal_enable <= 1;
      swap_request <= 1;
      s = steer_select;
      while (overlap_active !== 1'b1) @(posedge sys_clk);
      for (n = 0; overlap_active === 1'b1; n++) @(posedge sys_clk);
      chk("overlap len", 4 + 2 * v[k], n);
      for (n = 0; steer_select === s; n++) @(posedge sys_clk);
      // sequencer hand-off adds two edges to the programmed delay
      chk("steer delay", v[3-k] + 2, n);
      swap_request <= 0;
      repeat (5) @(posedge sys_clk);
    end
    $display("swap tests done");
  endtask : t_swap
  task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop
  // hang guard, well above the run length
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      report_and_stop;
    end
  end
  initial begin
    t_reset(8'h5A);
    t_fields;
    t_unmapped;
    t_swap;
    // second reset in mid-run, with a new fuse value
    apb(1, DITHER_IDX, 0, 32'h7);
    t_reset(8'hC3);
    report_and_stop;
  end
endmodule : test_asd_config_regs
bind asd_config_regs asd_config_regs_monitor #(.ADDR_W(ADDR_W)) mon (
  .sys_clk, .rst_b, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
  .pslverr, .input_d_termination_trim, .dither_enable,
  .dither_amplitude_select, .dither_rounding_select, .overlap_active,
  .steer_select, .swap_busy);
